//--- hdl/sbs_top.v
// Status byte, service request, self-test and command sequencing logic.
`timescale 1ns/1ps
`include "sbs_consts.vh"
// How it works
// R1: Eight-bit enable mask, any value writable, readable, zero after reset.
// R2: Status bit 6 is OR of status bits enabled by the mask.
// R3: Serial poll clears the request-for-service flag, summary bit stays.
// R4: A zero enable mask never raises a service request.
// R5: Status byte query returns the current byte and clears nothing.
// R6: Serial poll answer is status byte with request flag in bit 6.
// R7: Bit 6 request, bit 5 event summary, bit 4 message available, bit 0 amplifier.
// R8: Summary bits follow their event registers only.
// R9: Self-test resets link, opens relay, programs zero volts, reads voltage back.
// R10: Self-test answers zero on success, a non-zero code otherwise.
// R11: Error code carries a base for the failing step, 100H to 800H.
// R12: Failure part is transmit code plus 010H for status or 020H for command.
// R13: Every amplifier command is preceded by a status request.
// R14: Transmit codes 081H, 083H-085H, 0C1H, 0C3H, 0CFH come from the link.
// R15: Wait stalls commands until all earlier ones, overlapped too, finish.
// R16: Voltage, state, relay and trigger commands overlap; others run in order.
// R17: Only a device clear aborts a pending wait.
// R18: In serial mode D reads version, w x y set one phase voltage.
// R19: Parameter key advances parameter from phase A in 1.0V; with shift tenfold.
// R20: Phase angle adjustment is limited to plus or minus 10 degrees.
// R21: Reading the standard event register returns it and clears it.
// R22: Service request line follows the request flag until a serial poll.
module sbs_top #(
    parameter VERSION = 16'h0001, // Arbitrary version value.
    parameter OVL_W = 4 // Width of the outstanding overlapped counter.
) (
    input wire MCLK_I, // 200 MHz clock.
    input wire RSTN_I, // Synchronous reset, active low.
    input wire CMD_VALID_I, // Command strobe.
    input wire [7:0] CMD_CODE_I, // Command code.
    input wire [15:0] CMD_DATA_I, // Command argument.
    output reg CMD_READY_O, // Command can be taken.
    output reg RESP_VALID_O, // Answer strobe.
    output reg [15:0] RESP_DATA_O, // Query answer.
    input wire [7:0] EVT_SET_I, // Event set pulses.
    input wire MAV_I, // Message available.
    input wire AMP_SUM_I, // Amplifier summary.
    input wire SPOLL_I, // Serial poll pin.
    input wire DCL_I, // Device clear pin.
    output reg SRQ_O, // Service request line.
    output reg [7:0] SPOLL_BYTE_O, // Serial poll answer.
    output reg [7:0] SRE_O, // Enable mask.
    output reg [7:0] STB_O, // Status byte.
    output reg OVL_START_O, // Overlapped command launched.
    input wire OVL_DONE_I, // Overlapped command finished.
    output reg LINK_REQ_O, // Link request pulse.
    output reg [2:0] LINK_OP_O, // Link operation.
    input wire LINK_DONE_I, // Link operation finished.
    input wire LINK_ERR_I, // Link operation failed.
    input wire [7:0] LINK_XCODE_I, // Transmit error code.
    input wire [15:0] LINK_DATA_I, // Read back voltage.
    input wire SERIAL_MODE_I, // Serial remote mode pin.
    input wire MODE_KEY_I, // Parameter-select key pin.
    input wire SHIFT_KEY_I, // Shift key pin.
    input wire UP_KEY_I, // Increment key pin.
    input wire DOWN_KEY_I, // Decrement key pin.
    output reg [15:0] PHASE_A_O, // Phase A volts, tenths.
    output reg [15:0] PHASE_B_O, // Phase B volts, tenths.
    output reg [15:0] PHASE_C_O, // Phase C volts, tenths.
    output reg [7:0] ANGLE_B_O, // Phase B angle, signed degrees.
    output reg [7:0] ANGLE_C_O, // Phase C angle, signed degrees.
    output reg [2:0] PARAM_O // Selected manual parameter.
);
    // ******************************
    // Pin synchronisation
    // ******************************
    wire [6:0] pin_s;
    sbs_sync3 #(
        .W(7)
    ) u_sync (
        .clk_i(MCLK_I),
        .rstn_i(RSTN_I),
        .d_i({SPOLL_I, DCL_I, SERIAL_MODE_I, MODE_KEY_I, SHIFT_KEY_I, UP_KEY_I, DOWN_KEY_I}),
        .q_o(pin_s)
    );
    reg [6:0] pin_q;
    always @(posedge MCLK_I) begin
        if (!RSTN_I) begin
            pin_q <= 7'h00;
        end else begin
            pin_q <= pin_s;
        end
    end
    wire poll_p = pin_s[6] & ~pin_q[6];
    wire dcl_p = pin_s[5] & ~pin_q[5];
    wire serial_m = pin_s[4];
    wire mode_p = pin_s[3] & ~pin_q[3];
    wire shift_p = pin_s[2] & ~pin_q[2];
    wire up_p = pin_s[1] & ~pin_q[1];
    wire down_p = pin_s[0] & ~pin_q[0];
    // ******************************
    // Status byte and service request
    // ******************************
    reg [7:0] esr_q;
    reg coarse_q;
    wire take = CMD_VALID_I & CMD_READY_O;
    wire esr_rd = take & (CMD_CODE_I == `SBS_CMD_ESR_RD);
    wire [7:0] stb_lo = {1'b0, 1'b0, |esr_q, MAV_I, 3'b000, AMP_SUM_I}; // see R7 see R8
    wire mss = |(stb_lo & SRE_O); // see R2 see R4
    wire [7:0] stb = stb_lo | ({7'h00, mss} << `SBS_STB_RQS);
    reg mss_q;
    always @(posedge MCLK_I) begin
        if (!RSTN_I) begin
            SRE_O <= `SBS_SRE_RST;
            esr_q <= 8'h00;
            mss_q <= 1'b0;
            SRQ_O <= 1'b0;
            STB_O <= 8'h00;
            SPOLL_BYTE_O <= 8'h00;
        end else begin
            if (take && CMD_CODE_I == `SBS_CMD_SRE_WR) begin
                SRE_O <= CMD_DATA_I[7:0]; // see R1
            end
            // A new event in the clearing read survives it.
            esr_q <= (esr_rd ? 8'h00 : esr_q) | EVT_SET_I; // see R21
            mss_q <= mss;
            STB_O <= stb;
            // Request rises with the summary; a new rise beats the poll clear.
            if (mss && !mss_q) begin
                SRQ_O <= 1'b1; // see R22
            end else if (poll_p) begin
                SRQ_O <= 1'b0; // see R3 see R22
            end
            if (poll_p) begin
                SPOLL_BYTE_O <= stb_lo | ({7'h00, SRQ_O} << `SBS_STB_RQS); // see R6
            end
        end
    end
    // ******************************
    // Self-test sequencer
    // ******************************
    localparam ST_IDLE = 2'd0;
    localparam ST_REQ = 2'd1;
    localparam ST_WAIT = 2'd2;
    reg [1:0] st_q;
    reg [1:0] step_q;
    reg phase_q;
    wire [2:0] step_op = (step_q == 2'd0) ? `SBS_OP_RESET : (step_q == 2'd1) ? `SBS_OP_OPEN :
        (step_q == 2'd2) ? `SBS_OP_ZERO : `SBS_OP_READ; // see R9
    wire [11:0] step_base = (step_q == 2'd0) ? `SBS_BASE_RESET :
        (step_q == 2'd1) ? `SBS_BASE_OPEN :
        (step_q == 2'd2) ? `SBS_BASE_ZERO : `SBS_BASE_READ; // see R11
    wire tst_start = take & (CMD_CODE_I == `SBS_CMD_TST_RD);
    wire [11:0] fail_code = step_base + (phase_q ? `SBS_CODE_SEND : `SBS_CODE_STATUS)
        + {4'h0, LINK_XCODE_I}; // see R11 see R12 see R14
    wire tst_end = (st_q == ST_WAIT) & LINK_DONE_I & (LINK_ERR_I | (phase_q & step_q == 2'd3));
    wire [15:0] tst_res = LINK_ERR_I ? {4'h0, fail_code} :
        (LINK_DATA_I != 16'h0000) ? {4'h0, `SBS_BASE_NOZERO} : 16'h0000; // see R10
    always @(posedge MCLK_I) begin
        if (!RSTN_I) begin
            st_q <= ST_IDLE;
            step_q <= 2'd0;
            phase_q <= 1'b0;
            LINK_REQ_O <= 1'b0;
            LINK_OP_O <= `SBS_OP_STATUS;
        end else begin
            LINK_REQ_O <= 1'b0;
            case (st_q)
                ST_IDLE: begin
                    if (tst_start) begin
                        step_q <= 2'd0;
                        phase_q <= 1'b0;
                        st_q <= ST_REQ;
                    end
                end
                ST_REQ: begin
                    // Status first, then the step's own command.
                    LINK_OP_O <= phase_q ? step_op : `SBS_OP_STATUS; // see R13 see R9
                    LINK_REQ_O <= 1'b1;
                    st_q <= ST_WAIT;
                end
                ST_WAIT: begin
                    if (tst_end) begin
                        st_q <= ST_IDLE;
                    end else if (LINK_DONE_I) begin
                        phase_q <= ~phase_q;
                        if (phase_q) begin
                            step_q <= step_q + 2'd1; // see R9
                        end
                        st_q <= ST_REQ;
                    end
                end
                default: st_q <= ST_IDLE;
            endcase
        end
    end
    // ******************************
    // Command sequencing, wait and answers
    // ******************************
    wire [15:0] step = coarse_q ? `SBS_STEP_COARSE : `SBS_STEP_FINE; // see R19
    reg [OVL_W-1:0] ovl_q;
    reg wait_q;
    wire is_ovl = (CMD_CODE_I == `SBS_CMD_OVL) | (serial_m & ((CMD_CODE_I == `SBS_CMD_PHA) |
        (CMD_CODE_I == `SBS_CMD_PHB) | (CMD_CODE_I == `SBS_CMD_PHC))); // see R16 see R18
    wire ovl_go = take & is_ovl;
    wire [OVL_W-1:0] ovl_d = ovl_q + {{(OVL_W-1){1'b0}}, ovl_go}
        - {{(OVL_W-1){1'b0}}, OVL_DONE_I & (ovl_q != {OVL_W{1'b0}})};
    wire ovl_full = &ovl_q;
    wire wait_d = dcl_p ? 1'b0 : // see R17
        (take & CMD_CODE_I == `SBS_CMD_WAIT) ? 1'b1 :
        (ovl_d == {OVL_W{1'b0}}) ? 1'b0 : wait_q; // see R15
    wire st_d_busy = tst_start | ((st_q != ST_IDLE) & ~tst_end); // see R16
    always @(posedge MCLK_I) begin
        if (!RSTN_I) begin
            ovl_q <= {OVL_W{1'b0}};
            wait_q <= 1'b0;
            CMD_READY_O <= 1'b0;
            OVL_START_O <= 1'b0;
            RESP_VALID_O <= 1'b0;
            RESP_DATA_O <= 16'h0000;
            PHASE_A_O <= 16'h0000;
            PHASE_B_O <= 16'h0000;
            PHASE_C_O <= 16'h0000;
        end else begin
            ovl_q <= ovl_d;
            wait_q <= wait_d;
            CMD_READY_O <= ~wait_d & ~st_d_busy & ~(ovl_full & ~OVL_DONE_I) & ~take;
            OVL_START_O <= ovl_go;
            RESP_VALID_O <= 1'b0;
            if (tst_end) begin
                RESP_VALID_O <= 1'b1;
                RESP_DATA_O <= tst_res;
            end else if (take) begin
                case (CMD_CODE_I)
                    `SBS_CMD_SRE_RD: begin
                        RESP_VALID_O <= 1'b1;
                        RESP_DATA_O <= {8'h00, SRE_O}; // see R1
                    end
                    `SBS_CMD_STB_RD: begin
                        RESP_VALID_O <= 1'b1;
                        RESP_DATA_O <= {8'h00, stb}; // see R5
                    end
                    `SBS_CMD_ESR_RD: begin
                        RESP_VALID_O <= 1'b1;
                        RESP_DATA_O <= {8'h00, esr_q}; // see R21
                    end
                    `SBS_CMD_VER_RD: begin
                        RESP_VALID_O <= serial_m; // see R18
                        RESP_DATA_O <= VERSION;
                    end
                    default: RESP_DATA_O <= RESP_DATA_O;
                endcase
            end
            if (ovl_go && CMD_CODE_I == `SBS_CMD_PHA) begin
                PHASE_A_O <= CMD_DATA_I; // see R18
            end
            if (ovl_go && CMD_CODE_I == `SBS_CMD_PHB) begin
                PHASE_B_O <= CMD_DATA_I;
            end
            if (ovl_go && CMD_CODE_I == `SBS_CMD_PHC) begin
                PHASE_C_O <= CMD_DATA_I;
            end
            // ******************************
            // Manual adjustment; keys act only outside serial mode.
            // ******************************
            if (!serial_m && (up_p || down_p)) begin
                case (PARAM_O)
                    3'd0: PHASE_A_O <= up_p ? PHASE_A_O + step : PHASE_A_O - step;
                    3'd1: PHASE_B_O <= up_p ? PHASE_B_O + step : PHASE_B_O - step;
                    3'd2: PHASE_C_O <= up_p ? PHASE_C_O + step : PHASE_C_O - step;
                    default: PHASE_A_O <= PHASE_A_O;
                endcase
            end
        end
    end
    function [7:0] ang_adj;
        input [7:0] a;
        input up;
        begin
            // Signed compare keeps the offset inside the allowed window.
            if (up && ($signed(a) < $signed(`SBS_ANGLE_LIM))) begin
                ang_adj = a + 8'h01; // see R20
            end else if (!up && ($signed(a) > -$signed(`SBS_ANGLE_LIM))) begin
                ang_adj = a - 8'h01; // see R20
            end else begin
                ang_adj = a;
            end
        end
    endfunction
    always @(posedge MCLK_I) begin
        if (!RSTN_I) begin
            PARAM_O <= 3'd0;
            coarse_q <= 1'b0;
            ANGLE_B_O <= 8'h00;
            ANGLE_C_O <= 8'h00;
        end else if (!serial_m) begin
            if (mode_p) begin
                PARAM_O <= (PARAM_O == `SBS_NUM_PARAMS - 3'd1) ? 3'd0 : PARAM_O + 3'd1; // see R19
                coarse_q <= 1'b0;
            end else if (shift_p && pin_s[3]) begin
                coarse_q <= 1'b1; // see R19
            end
            if ((up_p || down_p) && PARAM_O == 3'd3) begin
                ANGLE_B_O <= ang_adj(ANGLE_B_O, up_p);
            end
            if ((up_p || down_p) && PARAM_O == 3'd4) begin
                ANGLE_C_O <= ang_adj(ANGLE_C_O, up_p);
            end
        end
    end
endmodule // sbs_top

//--- hdl/sbs_consts.vh
// Constants for the status byte, self-test and command sequencer.
`ifndef SBS_CONSTS_VH
`define SBS_CONSTS_VH
// Command codes presented by the command parser.
`define SBS_CMD_SRE_WR 8'h01
`define SBS_CMD_SRE_RD 8'h02
`define SBS_CMD_STB_RD 8'h03
`define SBS_CMD_ESR_RD 8'h04
`define SBS_CMD_TST_RD 8'h05
`define SBS_CMD_WAIT 8'h06
`define SBS_CMD_OVL 8'h07
`define SBS_CMD_VER_RD 8'h44
`define SBS_CMD_PHA 8'h77
`define SBS_CMD_PHB 8'h78
`define SBS_CMD_PHC 8'h79
// Status byte field positions.
`define SBS_STB_RQS 6
`define SBS_STB_ESB 5
`define SBS_STB_MAV 4
`define SBS_STB_AMP 0
`define SBS_SRE_RST 8'h00
// Amplifier link operations.
`define SBS_OP_STATUS 3'h0
`define SBS_OP_RESET 3'h1
`define SBS_OP_OPEN 3'h2
`define SBS_OP_ZERO 3'h3
`define SBS_OP_READ 3'h4
// Self-test error code parts.
`define SBS_BASE_RESET 12'h100
`define SBS_BASE_OPEN 12'h300
`define SBS_BASE_ZERO 12'h600
`define SBS_BASE_NOZERO 12'h700
`define SBS_BASE_READ 12'h800
`define SBS_CODE_STATUS 12'h010
`define SBS_CODE_SEND 12'h020
// Manual mode steps in tenths of a volt, angle limit in degrees.
`define SBS_STEP_FINE 16'h000A
`define SBS_STEP_COARSE 16'h0064
`define SBS_ANGLE_LIM 8'h0A
`define SBS_NUM_PARAMS 3'h5
`endif

//--- hdl/sbs_sync3.v
// Three-stage input synchroniser that accepts a change once stages two and three agree.
`timescale 1ns/1ps
module sbs_sync3 #(
    parameter W = 1
) (
    input wire clk_i, // Clock.
    input wire rstn_i, // Synchronous reset, active low.
    input wire [W-1:0] d_i, // Asynchronous inputs.
    output reg [W-1:0] q_o // Filtered inputs.
);
    reg [W-1:0] s1_q;
    reg [W-1:0] s2_q;
    reg [W-1:0] s3_q;
    integer i;
    always @(posedge clk_i) begin
        if (!rstn_i) begin
            s1_q <= {W{1'b0}};
            s2_q <= {W{1'b0}};
            s3_q <= {W{1'b0}};
            q_o <= {W{1'b0}};
        end else begin
            s1_q <= d_i;
            s2_q <= s1_q;
            s3_q <= s2_q;
            for (i = 0; i < W; i = i + 1) begin
                if (s2_q[i] == s3_q[i]) begin
                    q_o[i] <= s3_q[i];
                end
            end
        end
    end
endmodule // sbs_sync3

//--- testbench/sbs_top_properties.sv
// Concurrent checks on the status byte, service request, command and link ports.
`timescale 1ns/1ps
`include "sbs_consts.vh"
module sbs_top_properties (
    input wire MCLK_I, // Clock.
    input wire RSTN_I, // Synchronous reset, active low.
    input wire CMD_VALID_I, // Command strobe.
    input wire [7:0] CMD_CODE_I, // Command code.
    input wire [15:0] CMD_DATA_I, // Command argument.
    input wire CMD_READY_O, // Command ready.
    input wire RESP_VALID_O, // Answer strobe.
    input wire [15:0] RESP_DATA_O, // Answer.
    input wire MAV_I, // Message available.
    input wire AMP_SUM_I, // Amplifier summary.
    input wire SPOLL_I, // Serial poll pin.
    input wire SRQ_O, // Service request line.
    input wire [7:0] SRE_O, // Enable mask.
    input wire [7:0] STB_O, // Status byte.
    input wire LINK_REQ_O, // Link request pulse.
    input wire [2:0] LINK_OP_O // Link operation.
);
    // ******************************
    // Helper logic
    // ******************************
    default clocking cb @(posedge MCLK_I); endclocking
    default disable iff (!RSTN_I);
    wire take = CMD_VALID_I && CMD_READY_O;
    reg stat_q;
    reg [2:0] cmd_q;
    reg [7:0] wr_q;
    // A self-test may stop early on an error, so the step order restarts at each new test.
    always @(posedge MCLK_I) begin
        wr_q <= CMD_DATA_I[7:0];
        if (!RSTN_I || (take && CMD_CODE_I == `SBS_CMD_TST_RD)) begin
            stat_q <= 1'b0;
            cmd_q <= 3'h0;
        end else if (LINK_REQ_O) begin
            stat_q <= (LINK_OP_O == `SBS_OP_STATUS);
            if (LINK_OP_O != `SBS_OP_STATUS) begin
                cmd_q <= LINK_OP_O;
            end
        end
    end
    // ******************************
    // Properties
    // ******************************
    property p_mask_write;
        take && CMD_CODE_I == `SBS_CMD_SRE_WR |=> SRE_O == wr_q;
    endproperty
    a_mask_write: assert property (p_mask_write) else $error("mask write lost");
    property p_mask_read;
        take && CMD_CODE_I == `SBS_CMD_SRE_RD |=> RESP_VALID_O && RESP_DATA_O == {8'h00, SRE_O};
    endproperty
    a_mask_read: assert property (p_mask_read) else $error("mask read wrong");
    property p_summary;
        $stable(SRE_O) && $stable(STB_O[5:0]) ##1 $stable(SRE_O) && $stable(STB_O[5:0])
            |-> STB_O[6] == |(STB_O[5:0] & SRE_O[5:0]);
    endproperty
    a_summary: assert property (p_summary) else $error("summary bit wrong");
    property p_poll_clear;
        $rose(SPOLL_I) && SRQ_O |-> ##[1:10] !SRQ_O;
    endproperty
    a_poll_clear: assert property (p_poll_clear) else $error("poll kept request");
    property p_zero_mask;
        SRE_O == 8'h00 && !SRQ_O ##1 SRE_O == 8'h00 |-> !SRQ_O;
    endproperty
    a_zero_mask: assert property (p_zero_mask) else $error("request with zero mask");
    property p_unused;
        !STB_O[7] && STB_O[3:1] == 3'h0;
    endproperty
    a_unused: assert property (p_unused) else $error("unused status bit set");
    property p_follow;
        ($stable(MAV_I) && $stable(AMP_SUM_I)) [*3] |-> STB_O[4] == MAV_I && STB_O[0] == AMP_SUM_I;
    endproperty
    a_follow: assert property (p_follow) else $error("summary bit stale");
    property p_srq_cause;
        $rose(SRQ_O) |-> ##[0:2] STB_O[`SBS_STB_RQS];
    endproperty
    a_srq_cause: assert property (p_srq_cause) else $error("request without summary");
    property p_status_first;
        LINK_REQ_O && LINK_OP_O != `SBS_OP_STATUS |-> stat_q;
    endproperty
    a_status_first: assert property (p_status_first) else $error("command without status");
    property p_order;
        LINK_REQ_O && LINK_OP_O != `SBS_OP_STATUS |-> LINK_OP_O == cmd_q + 3'h1;
    endproperty
    a_order: assert property (p_order) else $error("self-test step order");
    c_srq: cover property ($rose(SRQ_O));
    c_read: cover property (LINK_REQ_O && LINK_OP_O == `SBS_OP_READ);
    c_tst: cover property (take && CMD_CODE_I == `SBS_CMD_TST_RD);
endmodule // sbs_top_properties

//--- testbench/sbs_amp_model.sv
// Behavioural amplifier link responder with one injectable failing request.
`timescale 1ns/1ps
module sbs_amp_model (
    input wire clk_i, // Clock.
    input wire clr_i, // Restart the request count.
    input wire req_i, // Link request pulse.
    input wire [3:0] fail_i, // Failing request index, 15 for none.
    input wire [7:0] code_i, // Transmit code on failure.
    input wire [15:0] rd_i, // Read back voltage.
    output reg done_o, // Operation finished.
    output reg err_o, // Operation failed.
    output reg [7:0] xcode_o, // Transmit code.
    output reg [15:0] data_o // Read back value.
);
    integer n = 0;
    integer w = 0;
    initial {done_o, err_o, xcode_o, data_o} = 0;
    // Odd requests answer slowly; code and data toggle outside done so stale values never pass.
    always @(posedge clk_i) begin
        done_o <= 1'b0;
        err_o <= 1'b0;
        xcode_o <= ~xcode_o;
        data_o <= ~data_o;
        if (clr_i) n <= 0;
        if (req_i) begin
            w <= (n % 2) ? 6 : 1;
            n <= n + 1;
        end else if (w > 0) begin
            w <= w - 1;
        end
        if (w == 1) begin
            done_o <= 1'b1;
            err_o <= (n - 1 == fail_i);
            xcode_o <= code_i;
            data_o <= rd_i;
        end
    end
endmodule // sbs_amp_model

//--- testbench/tb_sbs_top.sv
// Self-checking testbench for the status byte, self-test and sequencer block.
`timescale 1ns/1ps
`include "sbs_consts.vh"
module tb_sbs_top;
    reg clk = 0, rstn = 0, cv = 0, mav = 0, amp = 0, spoll = 0, dcl = 0, od = 0, clr = 0;
    reg sm = 0, mk = 0, sk = 0, uk = 0, dk = 0;
    reg [7:0] cc = 0, evt = 0, fc = 0;
    reg [15:0] cd = 0, rdv = 0, r, v;
    reg [3:0] fi = 4'hF;
    wire rdy, rv, srq, ost, lreq, ldone, lerr;
    wire [15:0] rd, lpa, lpb, lpc, ldat;
    wire [7:0] spb, mask, sbyte, angb, angc, lx;
    localparam [55:0] XC = 56'h81_8384_85C1_C3CF;
    wire [2:0] lop, par;
    integer err_total = 0, samples_checked = 0, i;
    sbs_top #(.VERSION(16'h1234)) i_dut (.MCLK_I(clk), .RSTN_I(rstn), .CMD_VALID_I(cv),
        .CMD_CODE_I(cc), .CMD_DATA_I(cd), .CMD_READY_O(rdy), .RESP_VALID_O(rv), .RESP_DATA_O(rd),
        .EVT_SET_I(evt), .MAV_I(mav), .AMP_SUM_I(amp), .SPOLL_I(spoll), .DCL_I(dcl), .SRQ_O(srq),
        .SPOLL_BYTE_O(spb), .SRE_O(mask), .STB_O(sbyte), .OVL_START_O(ost), .OVL_DONE_I(od),
        .LINK_REQ_O(lreq), .LINK_OP_O(lop), .LINK_DONE_I(ldone), .LINK_ERR_I(lerr),
        .LINK_XCODE_I(lx), .LINK_DATA_I(ldat), .SERIAL_MODE_I(sm), .MODE_KEY_I(mk),
        .SHIFT_KEY_I(sk), .UP_KEY_I(uk), .DOWN_KEY_I(dk), .PHASE_A_O(lpa), .PHASE_B_O(lpb),
        .PHASE_C_O(lpc), .ANGLE_B_O(angb), .ANGLE_C_O(angc), .PARAM_O(par));
    sbs_amp_model i_amp (.clk_i(clk), .clr_i(clr), .req_i(lreq), .fail_i(fi), .code_i(fc),
        .rd_i(rdv), .done_o(ldone), .err_o(lerr), .xcode_o(lx), .data_o(ldat));
    initial forever #2.5 clk = ~clk;
    // ******************************
    // Shared tasks
    // ******************************
    task give_verdict;
        begin
            $display("comparisons %0d, mismatches %0d", samples_checked, err_total);
            if (err_total == 0 && samples_checked > 0) $display("Testbench passed");
            else $display("Testbench failed");
            $finish;
        end
    endtask
    task chk(input [15:0] g, input [15:0] e);
        begin
            samples_checked = samples_checked + 1;
            if (g !== e) begin
                err_total = err_total + 1;
                $display("[ERR] %0t got %h expected %h", $time, g, e);
            end
        end
    endtask
    task cyc(input integer n);
        begin
            repeat (n) @(posedge clk);
            #1;
        end
    endtask
    task hang;
        begin
            err_total = err_total + 1;
            $display("[ERR] %0t wait ran out", $time);
            give_verdict;
        end
    endtask
    task cmd(input [7:0] c, input [15:0] d);
        integer n;
        begin
            for (n = 0; rdy !== 1'b1; n = n + 1) begin
                if (n > 400) hang;
                cyc(1);
            end
            {cv, cc, cd} = {1'b1, c, d};
            cyc(1);
            cv = 0;
        end
    endtask
    task query(input [7:0] c);
        integer n;
        begin
            cmd(c, 16'h0000);
            for (n = 0; rv !== 1'b1; n = n + 1) begin
                if (n > 400) hang;
                cyc(1);
            end
            r = rd;
        end
    endtask
    task poll;
        begin
            spoll = 1;
            cyc(8);
            spoll = 0;
            cyc(3);
        end
    endtask
    // The shift bit is raised while mode is already held, as an operator would.
    task press(input [2:0] m);
        begin
            {mk, uk} = {m[2], m[0]};
            cyc(6);
            sk = m[1];
            cyc(6);
            {mk, sk, uk} = 3'h0;
            cyc(8);
        end
    endtask
    // ******************************
    // Scenarios
    // ******************************
    task t_mask;
        begin
            query(`SBS_CMD_SRE_RD);
            chk(r, 16'h0000);
            for (i = 0; i < 3; i = i + 1) begin
                v = (i == 0) ? 16'h00FF : (i == 1) ? 16'h00A5 : 16'h0000;
                cmd(`SBS_CMD_SRE_WR, v);
                query(`SBS_CMD_SRE_RD);
                chk(r, v);
            end
        end
    endtask
    task t_status;
        begin
            {mav, amp} = 2'b11;
            cyc(6);
            query(`SBS_CMD_STB_RD);
            chk(r, 16'h0011);
            query(`SBS_CMD_STB_RD);
            chk(r, 16'h0011);
            chk(srq, 0);
            cmd(`SBS_CMD_SRE_WR, 16'h0010);
            cyc(4);
            chk(sbyte, 8'h51);
            chk(srq, 1);
            poll;
            chk(spb, 8'h51);
            chk(srq, 0);
            query(`SBS_CMD_STB_RD);
            chk(r, 16'h0051);
            poll;
            chk(spb, 8'h11);
            mav = 0;
            cyc(4);
            chk(sbyte, 8'h01);
        end
    endtask
    task t_event;
        begin
            cmd(`SBS_CMD_SRE_WR, 16'h0000);
            evt = 8'h20;
            cyc(1);
            evt = 0;
            cyc(3);
            chk(sbyte[5], 1);
            query(`SBS_CMD_ESR_RD);
            chk(r, 16'h0020);
            cyc(3);
            chk(sbyte[5], 0);
        end
    endtask
    task t_selftest;
        begin
            for (i = 0; i < 10; i = i + 1) begin
                {clr, fi, rdv} = {1'b1, (i < 8) ? i[3:0] : 4'hF, (i == 9) ? 16'h0005 : 16'h0000};
                fc = XC[55 - 8 * (i % 7) -: 8];
                v = (i < 2) ? `SBS_BASE_RESET : (i < 4) ? `SBS_BASE_OPEN :
                    (i < 6) ? `SBS_BASE_ZERO : `SBS_BASE_READ;
                v = v + ((i % 2) ? `SBS_CODE_SEND : `SBS_CODE_STATUS) + fc;
                if (i > 7) v = (i == 9) ? {4'h0, `SBS_BASE_NOZERO} : 16'h0000;
                cyc(1);
                clr = 0;
                query(`SBS_CMD_TST_RD);
                chk(r, v);
            end
        end
    endtask
    task t_wait;
        begin
            cmd(`SBS_CMD_OVL, 16'h0000);
            chk(ost, 1);
            cyc(1);
            chk(rdy, 1);
            cmd(`SBS_CMD_WAIT, 16'h0000);
            cyc(10);
            chk(rdy, 0);
            od = 1;
            cyc(1);
            od = 0;
            cyc(3);
            chk(rdy, 1);
            cmd(`SBS_CMD_OVL, 16'h0000);
            cmd(`SBS_CMD_WAIT, 16'h0000);
            cyc(10);
            chk(rdy, 0);
            dcl = 1;
            cyc(8);
            dcl = 0;
            cyc(3);
            chk(rdy, 1);
        end
    endtask
    task t_manual;
        begin
            v = lpa;
            press(3'b001);
            chk(lpa, v + `SBS_STEP_FINE);
            v = lpb;
            press(3'b110);
            chk(par, 3'h1);
            press(3'b001);
            chk(lpb, v + `SBS_STEP_COARSE);
            press(3'b100);
            press(3'b100);
            chk(par, 3'h3);
            for (i = 0; i < 12; i = i + 1) press(3'b001);
            chk(angb, 8'h0A);
            press(3'b100);
            for (i = 0; i < 12; i = i + 1) begin
                dk = 1;
                cyc(8);
                dk = 0;
                cyc(8);
            end
            chk(angc, 8'hF6);
        end
    endtask
    task t_serial;
        begin
            v = lpc;
            cmd(`SBS_CMD_PHC, 16'h0123);
            cyc(2);
            chk(lpc, v);
            sm = 1;
            cyc(8);
            cmd(`SBS_CMD_PHA, 16'h0064);
            cmd(`SBS_CMD_PHB, 16'h0065);
            cmd(`SBS_CMD_PHC, 16'h0066);
            cyc(2);
            chk(lpa, 16'h0064);
            chk(lpb, 16'h0065);
            chk(lpc, 16'h0066);
            query(`SBS_CMD_VER_RD);
            chk(r, 16'h1234);
        end
    endtask
    initial begin
        cyc(8);
        rstn = 1;
        cyc(2);
        chk(mask, 8'h00);
        t_mask;
        t_status;
        t_event;
        t_selftest;
        t_wait;
        t_manual;
        t_serial;
        give_verdict;
    end
endmodule // tb_sbs_top
bind sbs_top sbs_top_properties i_chk (.*);
